// ===== bench/modem_line_partner.sv
// modem or data set model: rx serial, infrared rx and modem status pins
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/100ps
module modem_line_partner (
    input  wire logic ref_clk,
    input  wire logic rtsPinN,
    output logic      serialIn,
    output logic      infraredInN,
    output logic      ctsPinN,
    output logic      dsrPinN,
    output logic      dcdPinN,
    output logic      ring_indicator_pin
);
    // lines idle at mark, status pins deasserted
    initial begin
        {serialIn, infraredInN, ctsPinN, dsrPinN, dcdPinN, ring_indicator_pin} = 6'h3f;
    end
    task automatic setModem(input logic [3:0] v);
        {ctsPinN, dsrPinN, dcdPinN, ring_indicator_pin} <= v;
    endtask
    // one bit is 16 ticks; infrared break pulses low 3 ticks of every bit
    task automatic breakLine(input logic ir, input int nBits);
        for (int i = 0; i < nBits * 16; i++) begin
            serialIn <= ir;
            infraredInN <= ir ? (i % 16 >= 3) : 1'b1;
            @(posedge ref_clk);
        end
        serialIn <= 1'b1;
        infraredInN <= 1'b1;
    endtask
endmodule

// ===== bench/uart_modem_ctrl_line_status_tb.sv
// bench for modem-control pins, loopback routing and line-status flags
// assumes the 10 MHz clock, ahb-lite master tasks and one tick per cycle
`timescale 1ns/100ps
module uart_modem_ctrl_line_status_tb;
    import uart_mcls_pkg::*;
    logic        ref_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  charBits;
    logic        serialIn, serialOut, infraredInN, infraredOutN, ctsPinN, dsrPinN, dcdPinN;
    logic        ring_indicator_pin, rtsPinN, user_output_one_pin, user_output_two_pin;
    logic        txSerial, infraredTxN, baudTick, fifoEnable, thresholdMode, threIntEnable;
    logic        rxAboveTrigger, rxPush, rxPushError, rxPop, rxHeadError, rxHeadBreak;
    logic        txFifoEmpty, txFifoFull, txFifoBelowThreshold, txShiftEmpty, txLoad;
    logic        holdingWrite, rxSerialInt, infraredRxInt, ctsActive, dsrActive;
    logic        ringActive, dcdActive, autoFlowActive, breakChar, threIrq;
    logic [15:0] modem_control;
    logic        holdE, brk, rfe;
    int          errCnt, nBreak, cycles, nFail, checksDone;
    int          seed = 68398;
    assign hready = hreadyout;
    uart_modem_ctrl_line_status uart_modem_ctrl_line_status_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .serialIn(serialIn), .serialOut(serialOut), .infraredInN(infraredInN),
        .infraredOutN(infraredOutN), .ctsPinN(ctsPinN), .dsrPinN(dsrPinN),
        .dcdPinN(dcdPinN), .ring_indicator_pin(ring_indicator_pin), .rtsPinN(rtsPinN),
        .user_output_one_pin(user_output_one_pin), .user_output_two_pin(user_output_two_pin),
        .txSerial(txSerial), .infraredTxN(infraredTxN), .baudTick(baudTick),
        .charBits(charBits), .fifoEnable(fifoEnable), .thresholdMode(thresholdMode),
        .threIntEnable(threIntEnable), .rxAboveTrigger(rxAboveTrigger), .rxPush(rxPush),
        .rxPushError(rxPushError), .rxPop(rxPop), .rxHeadError(rxHeadError),
        .rxHeadBreak(rxHeadBreak), .txFifoEmpty(txFifoEmpty), .txFifoFull(txFifoFull),
        .txFifoBelowThreshold(txFifoBelowThreshold), .txShiftEmpty(txShiftEmpty),
        .txLoad(txLoad), .holdingWrite(holdingWrite), .rxSerialInt(rxSerialInt),
        .infraredRxInt(infraredRxInt), .ctsActive(ctsActive), .dsrActive(dsrActive),
        .ringActive(ringActive), .dcdActive(dcdActive), .autoFlowActive(autoFlowActive),
        .breakChar(breakChar), .threIrq(threIrq)
    );
    modem_line_partner modem_line_partner_inst (
        .ref_clk(ref_clk), .rtsPinN(rtsPinN), .serialIn(serialIn), .infraredInN(infraredInN),
        .ctsPinN(ctsPinN), .dsrPinN(dsrPinN), .dcdPinN(dcdPinN),
        .ring_indicator_pin(ring_indicator_pin)
    );
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (breakChar === 1'b1) nBreak++;
        if (cycles == 20000) begin
            nFail++;
            finalReport();
        end
    end
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        if (a == MODEM_CONTROL_ADDR) modem_control = d[15:0] & MODEM_CONTROL_MASK;
    endtask
    task automatic rdChk(input logic [31:0] a, exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask
    // mask order: push, pop, load, holding write
    task automatic pulse(input logic [3:0] m);
        @(posedge ref_clk);
        {rxPush, rxPop, txLoad, holdingWrite} <= m;
        @(posedge ref_clk);
        {rxPush, rxPop, txLoad, holdingWrite} <= 4'h0;
    endtask
    task automatic line_status();
        logic t, th;
        @(negedge ref_clk);
        t = fifoEnable ? (txFifoEmpty & txShiftEmpty) : (holdE & txShiftEmpty);
        th = thresholdMode & fifoEnable;
        chk(threIrq, {th ? txFifoBelowThreshold & threIntEnable : holdE & threIntEnable});
        rdChk(LINE_STATUS_ADDR, {24'h0, rfe, t, th ? txFifoFull : holdE, brk, 4'h0});
        brk = 1'b0;
        if (rxHeadError && errCnt <= 1) rfe = 1'b0;
    endtask
    task automatic pins();
        logic lb, ir, af;
        lb = modem_control[LOOPBACK_POS];
        ir = modem_control[INFRARED_POS];
        af = modem_control[AUTO_FLOW_POS] & fifoEnable;
        chk(rtsPinN, {lb | ~(modem_control[RTS_POS] & ~(af & rxAboveTrigger))});
        chk(user_output_one_pin, {lb | ~modem_control[USER_OUTPUT_ONE_POS]});
        chk(user_output_two_pin, {lb | ~modem_control[USER_OUTPUT_TWO_POS]});
        chk(autoFlowActive, af);
        chk(ctsActive, {lb ? modem_control[RTS_POS] : ~ctsPinN});
        chk(dsrActive, {~lb & ~dsrPinN});
        chk(ringActive, {lb ? modem_control[USER_OUTPUT_ONE_POS] : ~ring_indicator_pin});
        chk(dcdActive, {lb ? modem_control[USER_OUTPUT_TWO_POS] : ~dcdPinN});
        if (!ir) chk({serialOut, rxSerialInt}, {lb | txSerial, lb ? txSerial : serialIn});
        else chk({infraredOutN, infraredRxInt},
                 {~lb & infraredTxN, lb ? ~txSerial : infraredInN});
    endtask
    task automatic doReset();
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        {modem_control, holdE, brk, rfe, errCnt} = {16'h0, 3'b100, 32'd0};
        rdChk(MODEM_CONTROL_ADDR, 32'h0);
        line_status();
    endtask
    task automatic breakRun(input logic ir);
        nBreak = 0;
        modem_line_partner_inst.breakLine(ir, 14);
        repeat (4) @(posedge ref_clk);
        chk(nBreak, 1);
        brk = 1'b1;
        line_status();
        line_status();
    endtask
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, hsize, baudTick, charBits} = {36'h0, 32'h0, 3'h2, 5'h1a};
        {txSerial, infraredTxN, fifoEnable, thresholdMode, threIntEnable} = 5'h19;
        {rxAboveTrigger, rxPush, rxPushError, rxPop, rxHeadError, rxHeadBreak} = 6'h0;
        {txFifoEmpty, txFifoFull, txFifoBelowThreshold, txShiftEmpty, txLoad, holdingWrite} = 6'h24;
        reset_n = 1'b0;
        doReset();
        wr(LINE_STATUS_ADDR, 32'hffffffff);
        wr(32'h50001118, 32'hffffffff);
        rdChk(32'h50001118, 32'h0);
        line_status();
        repeat (32) begin
            @(posedge ref_clk);
            {txSerial, infraredTxN, fifoEnable, rxAboveTrigger} <= 4'($random(seed));
            modem_line_partner_inst.setModem(4'($random(seed)));
            wr(MODEM_CONTROL_ADDR, $random(seed));
            @(negedge ref_clk);
            pins();
            rdChk(MODEM_CONTROL_ADDR, {16'h0, modem_control});
        end
        wr(MODEM_CONTROL_ADDR, 32'h10);
        fifoEnable <= 1'b0;
        txShiftEmpty <= 1'b0;
        pulse(4'b0001);
        holdE = 1'b0;
        line_status();
        pulse(4'b0010);
        holdE = 1'b1;
        txShiftEmpty <= 1'b1;
        line_status();
        pulse(4'b0011);
        holdE = 1'b0;
        line_status();
        {fifoEnable, thresholdMode, txFifoFull, txFifoBelowThreshold, txFifoEmpty} <= 5'h1c;
        line_status();
        {txFifoFull, txFifoBelowThreshold, txFifoEmpty} <= 3'b011;
        line_status();
        {fifoEnable, thresholdMode} <= 2'b00;
        wr(MODEM_CONTROL_ADDR, 32'h0);
        breakRun(1'b0);
        wr(MODEM_CONTROL_ADDR, 32'h40);
        breakRun(1'b1);
        {fifoEnable, rxHeadBreak} <= 2'b11;
        pulse(4'b0100);
        brk = 1'b1;
        line_status();
        rxHeadBreak <= 1'b0;
        doReset();
        {fifoEnable, rxPushError} <= 2'b11;
        pulse(4'b1000);
        {errCnt, rfe} = {32'd1, 1'b1};
        line_status();
        rxHeadError <= 1'b1;
        line_status();
        line_status();
        pulse(4'b1000);
        {errCnt, rfe} = {32'd2, 1'b1};
        line_status();
        line_status();
        // popping the errored head leaves one stored error, now clearable
        pulse(4'b0100);
        errCnt = 1;
        line_status();
        line_status();
        finalReport();
    end
endmodule

// ===== hw/uart_mcls_pkg.sv
// constants for the modem-control and line-status block
// assumes a 32-bit AHB-Lite fabric and a 16x baud tick from the divisor
package uart_mcls_pkg;
    // register byte addresses
    localparam logic [31:0] MODEM_CONTROL_ADDR = 32'h50001110;
    localparam logic [31:0] LINE_STATUS_ADDR   = 32'h50001114;

    // modem_control field positions
    localparam int USER_OUTPUT_ONE_POS  = 2;
    localparam int RTS_POS              = 1;
    localparam int USER_OUTPUT_TWO_POS  = 3;
    localparam int LOOPBACK_POS         = 4;
    localparam int AUTO_FLOW_POS        = 5;
    localparam int INFRARED_POS         = 6;
    localparam logic [15:0] MODEM_CONTROL_MASK = 16'h007e;

    // line_status field positions
    localparam int BREAK_POS            = 4;
    localparam int HOLDING_EMPTY_POS    = 5;
    localparam int TX_EMPTY_POS         = 6;
    localparam int RX_FIFO_ERROR_POS    = 7;

    // reset values
    localparam logic [5:0] MODEM_CONTROL_RST = 6'h00;
    localparam logic       TX_EMPTY_RST      = 1'h1;
    localparam logic       HOLDING_EMPTY_RST = 1'h1;
    localparam logic       RX_FIFO_ERROR_RST = 1'h0;
    localparam logic       BREAK_RST         = 1'h0;

    // break timing: oversample ticks per bit
    localparam logic [3:0] TICKS_PER_BIT_M1  = 4'hf;
    localparam int         ERR_COUNT_W       = 5;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'h0;
endpackage

// ===== hw/uart_modem_ctrl_line_status.sv
// modem-control outputs, loopback routing and upper line-status flags
// assumes tx/rx datapath, fifos and divisor live outside and feed status in
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps

// Overview of operation
// - plain loopback: serial out high, tx to rx
// - interrupts keep working during loopback
// - loopback swaps cts, ring and dcd inputs for modem outputs, dsr inactive
// - infrared loopback: ir out low, inverted feed
// - user output two pin inverted, high in loopback
// - user output one pin inverted, high in loopback
// - rts bit drives request pin inverted
// - auto flow forces request high above trigger
// - loopback holds request pin high
// - fifo error flag while errored character stored
// - status read clears only last head error
// - transmitter empty when shift and fifo empty, or shift and holding without fifos
// - holding empty sets on load without write
// - threshold mode shows fifo full, threshold irq
// - plain break: line low over character time
// - infrared break: pulsed low over character time
// - break yields one zero character, marked
// - non-fifo break immediate, cleared by status read
// - reset values of flags and control bits
// - infrared bit selects infrared mode
// - auto flow only with fifos and bit
module uart_modem_ctrl_line_status
    import uart_mcls_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial pins
    input  wire logic        serialIn,
    output logic             serialOut,
    input  wire logic        infraredInN,
    output logic             infraredOutN,
    // modem pins, active low
    input  wire logic        ctsPinN,
    input  wire logic        dsrPinN,
    input  wire logic        dcdPinN,
    input  wire logic        ring_indicator_pin,
    output logic             rtsPinN,
    output logic             user_output_one_pin,
    output logic             user_output_two_pin,
    // from the uart core
    input  wire logic        txSerial,
    input  wire logic        infraredTxN,
    input  wire logic        baudTick,
    input  wire logic [3:0]  charBits,
    input  wire logic        fifoEnable,
    input  wire logic        thresholdMode,
    input  wire logic        threIntEnable,
    input  wire logic        rxAboveTrigger,
    input  wire logic        rxPush,
    input  wire logic        rxPushError,
    input  wire logic        rxPop,
    input  wire logic        rxHeadError,
    input  wire logic        rxHeadBreak,
    input  wire logic        txFifoEmpty,
    input  wire logic        txFifoFull,
    input  wire logic        txFifoBelowThreshold,
    input  wire logic        txShiftEmpty,
    input  wire logic        txLoad,
    input  wire logic        holdingWrite,
    // to the uart core
    output logic             rxSerialInt,
    output logic             infraredRxInt,
    output logic             ctsActive,
    output logic             dsrActive,
    output logic             ringActive,
    output logic             dcdActive,
    output logic             autoFlowActive,
    output logic             breakChar,
    output logic             threIrq
);

    // control and status flops
    logic [5:0]             modemCtl_r;
    logic                   txEmpty_r;
    logic                   holdingEmpty_r;
    logic                   rxFifoError_r;
    logic                   breakFlag_r;
    logic [ERR_COUNT_W-1:0] errCount_r;
    logic [ERR_COUNT_W-1:0] errCount_nxt;
    logic [3:0]             tickCnt_r;
    logic [3:0]             lowBits_r;
    logic                   bitLow_r;
    logic                   breakSeen_r;
    logic                   wrPend_r;
    logic [31:0]            wrAddr_r;
    logic [31:0]            rdData_r;

    // control fields, shifted down by one (bit 0 reserved)
    wire rtsBit          = modemCtl_r[RTS_POS-1];
    wire user_output_one_bit = modemCtl_r[USER_OUTPUT_ONE_POS-1];
    wire user_output_two_bit = modemCtl_r[USER_OUTPUT_TWO_POS-1];
    wire loopback_bit    = modemCtl_r[LOOPBACK_POS-1];
    wire auto_flow_enable_bit = modemCtl_r[AUTO_FLOW_POS-1];
    wire infrared_enable_bit  = modemCtl_r[INFRARED_POS-1];

    // ahb decode
    wire        busValid  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire        busRead   = busValid && !hwrite;
    wire        busWrite  = busValid && hwrite;
    wire        selMcr    = (haddr == MODEM_CONTROL_ADDR);
    wire        selLsr    = (haddr == LINE_STATUS_ADDR);
    wire        lsrRead   = busRead && selLsr;
    wire        mcrWrite  = wrPend_r && (wrAddr_r == MODEM_CONTROL_ADDR);

    // loopback and mode routing
    wire loopPlain = loopback_bit && !infrared_enable_bit;
    wire loopIr    = loopback_bit && infrared_enable_bit;
    // interrupt paths are never gated by loopback, so they work unchanged
    assign rxSerialInt   = loopback_bit ? txSerial : serialIn;
    assign serialOut     = loopPlain ? 1'h1 : txSerial;
    assign infraredOutN  = loopIr ? 1'h0 : infraredTxN;
    assign infraredRxInt = loopIr ? ~txSerial : infraredInN;

    // modem inputs, active high; dtr has no bit here so dsr loops inactive
    assign ctsActive  = loopback_bit ? rtsBit : ~ctsPinN;
    assign dsrActive  = loopback_bit ? 1'h0 : ~dsrPinN;
    assign ringActive = loopback_bit ? user_output_one_bit : ~ring_indicator_pin;
    assign dcdActive  = loopback_bit ? user_output_two_bit : ~dcdPinN;

    // modem outputs
    assign autoFlowActive = auto_flow_enable_bit && fifoEnable;
    wire   rtsAsserted    = rtsBit && !(autoFlowActive && rxAboveTrigger);
    assign rtsPinN        = loopback_bit ? 1'h1 : ~rtsAsserted;
    assign user_output_one_pin = loopback_bit ? 1'h1 : ~user_output_one_bit;
    assign user_output_two_pin = loopback_bit ? 1'h1 : ~user_output_two_bit;

    // transmit status
    wire txEmptyNow  = fifoEnable ? (txFifoEmpty && txShiftEmpty)
                                  : (holdingEmpty_r && txShiftEmpty);
    wire fifoThre    = thresholdMode && fifoEnable;
    wire holding_empty_flag = fifoThre ? txFifoFull : holdingEmpty_r;
    assign threIrq   = threIntEnable && (fifoThre ? txFifoBelowThreshold
                                                  : holdingEmpty_r);

    // receive fifo error bookkeeping: count errored entries stored
    wire errIn  = rxPush && rxPushError;
    wire errOut = rxPop && rxHeadError;
    always_comb begin
        errCount_nxt = errCount_r;
        if (!fifoEnable) begin
            errCount_nxt = '0;
        end else if (errIn && !errOut) begin
            errCount_nxt = errCount_r + 1'b1;
        end else if (errOut && !errIn && errCount_r != '0) begin
            errCount_nxt = errCount_r - 1'b1;
        end
    end
    // head error with none behind it is the only clearable case
    wire rfeClear = lsrRead && rxHeadError && (errCount_r <= 1);
    wire rfeSet   = fifoEnable && errIn;

    // break detection on the selected line, counted in whole bit times
    wire lineLevel = infrared_enable_bit ? infraredRxInt : rxSerialInt;
    wire bitEnd    = baudTick && (tickCnt_r == TICKS_PER_BIT_M1);
    // plain: low for the whole bit; infrared: at least one low pulse per bit
    wire bitWasLow = infrared_enable_bit ? (bitLow_r || !lineLevel)
                                         : (bitLow_r && !lineLevel);
    wire breakHit  = bitEnd && bitWasLow && (lowBits_r >= charBits) && !breakSeen_r;
    wire lineIdle  = !infrared_enable_bit && lineLevel;
    wire breakSet  = fifoEnable ? (rxHeadBreak && rxPop) : breakHit;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_r   <= 4'h0;
            bitLow_r    <= 1'h1;
            lowBits_r   <= 4'h0;
            breakSeen_r <= 1'h0;
        end else begin
            if (baudTick) begin
                tickCnt_r <= tickCnt_r + 4'h1;
            end
            if (bitEnd) begin
                bitLow_r <= !infrared_enable_bit;
                if (!bitWasLow) begin
                    lowBits_r   <= 4'h0;
                    breakSeen_r <= 1'h0;
                end else if (lowBits_r != 4'hf) begin
                    lowBits_r <= lowBits_r + 4'h1;
                end
            end else if (baudTick) begin
                bitLow_r <= bitWasLow;
            end
            if (lineIdle) begin
                breakSeen_r <= 1'h0;
            end else if (breakHit) begin
                breakSeen_r <= 1'h1;
            end
        end
    end
    assign breakChar = breakHit;

    // status and control registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            modemCtl_r     <= MODEM_CONTROL_RST;
            txEmpty_r      <= TX_EMPTY_RST;
            holdingEmpty_r <= HOLDING_EMPTY_RST;
            rxFifoError_r  <= RX_FIFO_ERROR_RST;
            breakFlag_r    <= BREAK_RST;
            errCount_r     <= '0;
        end else begin
            if (mcrWrite) begin
                modemCtl_r <= hwdata[6:1];
            end
            txEmpty_r  <= txEmptyNow;
            errCount_r <= errCount_nxt;
            // a write in the same cycle keeps the holding register full
            if (holdingWrite) begin
                holdingEmpty_r <= 1'h0;
            end else if (txLoad) begin
                holdingEmpty_r <= 1'h1;
            end
            if (rfeSet) begin
                rxFifoError_r <= 1'h1;
            end else if (rfeClear || !fifoEnable) begin
                rxFifoError_r <= 1'h0;
            end
            if (breakSet) begin
                breakFlag_r <= 1'h1;
            end else if (lsrRead) begin
                breakFlag_r <= 1'h0;
            end
        end
    end

    // line status image, reserved bits zero
    wire [31:0] lsrImage = {24'h000000, rxFifoError_r, txEmpty_r, holding_empty_flag,
                            breakFlag_r, 4'h0};
    wire [31:0] mcrImage = {25'h0000000, modemCtl_r, 1'h0};
    wire [31:0] rdMux    = selMcr ? mcrImage : (selLsr ? lsrImage : 32'h00000000);

    // zero-wait slave: read data registered at the address phase
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPend_r <= 1'h0;
            wrAddr_r <= 32'h00000000;
            rdData_r <= 32'h00000000;
        end else begin
            wrPend_r <= busWrite;
            if (busWrite) begin
                wrAddr_r <= haddr;
            end
            if (busRead) begin
                rdData_r <= rdMux;
            end
        end
    end
    assign hrdata    = rdData_r;
    assign hreadyout = 1'h1;
    assign hresp     = HRESP_OKAY;

    // checks
    property p_plain_loop;
        @(posedge ref_clk) disable iff (!reset_n)
        loopPlain |-> (serialOut == 1'h1) && (rxSerialInt == txSerial);
    endproperty
    a_plain_loop: assert property (p_plain_loop) else $error("plain loopback routing wrong");

    property p_ir_loop;
        @(posedge ref_clk) disable iff (!reset_n)
        loopIr |-> !infraredOutN && (infraredRxInt == !txSerial);
    endproperty
    a_ir_loop: assert property (p_ir_loop) else $error("infrared loopback routing wrong");

    property p_modem_loop;
        @(posedge ref_clk) disable iff (!reset_n)
        loopback_bit |-> ctsActive == rtsBit && ringActive == user_output_one_bit
                         && dcdActive == user_output_two_bit;
    endproperty
    a_modem_loop: assert property (p_modem_loop) else $error("modem inputs not looped");

    property p_pins_loop;
        @(posedge ref_clk) disable iff (!reset_n)
        loopback_bit |-> rtsPinN && user_output_one_pin && user_output_two_pin;
    endproperty
    a_pins_loop: assert property (p_pins_loop) else $error("modem pins not held high");

    property p_out_two;
        @(posedge ref_clk) disable iff (!reset_n)
        !loopback_bit |-> user_output_two_pin == !modemCtl_r[USER_OUTPUT_TWO_POS-1];
    endproperty
    a_out_two: assert property (p_out_two) else $error("user output two pin wrong");

    property p_flow_gate;
        @(posedge ref_clk) disable iff (!reset_n)
        !loopback_bit && fifoEnable && auto_flow_enable_bit && rxAboveTrigger |-> rtsPinN;
    endproperty
    a_flow_gate: assert property (p_flow_gate) else $error("rts not forced high");

    property p_mcr_write;
        @(posedge ref_clk) disable iff (!reset_n)
        mcrWrite |=> modemCtl_r == $past(hwdata[6:1]);
    endproperty
    a_mcr_write: assert property (p_mcr_write) else $error("modem control write lost");

    property p_break_read;
        @(posedge ref_clk) disable iff (!reset_n)
        lsrRead && !breakSet |=> !breakFlag_r;
    endproperty
    a_break_read: assert property (p_break_read) else $error("break not cleared by read");

    property p_break_now;
        @(posedge ref_clk) disable iff (!reset_n)
        !fifoEnable && breakHit |=> breakFlag_r;
    endproperty
    a_break_now: assert property (p_break_now) else $error("break flag late");

    property p_rfe_set;
        @(posedge ref_clk) disable iff (!reset_n)
        fifoEnable && rxPush && rxPushError |=> rxFifoError_r;
    endproperty
    a_rfe_set: assert property (p_rfe_set) else $error("fifo error flag not set");

    property p_holding;
        @(posedge ref_clk) disable iff (!reset_n)
        txLoad && !holdingWrite |=> holdingEmpty_r ##1 (holdingEmpty_r || $past(holdingWrite));
    endproperty
    a_holding: assert property (p_holding) else $error("holding empty not set");
endmodule
